// file: rtl/adt_unit.sv
// Purpose: divide control, instruction latch, mode, decode roms, timing
// Assumes: time-state inputs synchronous to core_clk, one-cycle pulses
// Notes: rom contents are parameters; blank roms decode to no command
module adt_unit
  import adt_pkg::*;
#(
  parameter logic [ROM_WORDS*ROM_DATA_W-1:0] ROM1_INIT = '1,
  parameter logic [ROM_WORDS*ROM_DATA_W-1:0] ROM2_INIT = '1
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire adt_cpu_time_s cpu_time,
  input wire logic [11:0] memory_data_lines,
  input wire logic arith_instr,
  input wire logic swap_to_extended_set,
  input wire logic swap_to_legacy_set,
  input wire logic [4:0] rom_addr,
  input wire logic div_start,
  input wire logic div_first_carry,
  input wire logic q_bit10,
  input wire logic q_bit11,
  input wire logic divide_sign_bit,
  input wire logic carry_out,
  input wire logic unit_start,
  input wire logic stop_cond,
  output logic [11:0] instruction_latch,
  output logic [11:0] instruction_latch_n,
  output adt_mode_e mode,
  output logic [7:0] rom1_out_n,
  output logic [7:0] rom2_out_n,
  output logic ma_increment,
  output adt_div_ctl_s div_ctl,
  output logic div_active,
  output logic link_bit,
  output logic unit_time_pulse,
  output logic unit_active_ff,
  output logic [3:0] step_counter
);
  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // instruction latch
  // ---------------------------------------------------------------
  logic latch_clr;
  // interrupt without data break clears at tp4, else at fetch tp1
  assign latch_clr = (cpu_time.irq_pending && !cpu_time.data_break)
    ? cpu_time.tp4 : (cpu_time.fetch && cpu_time.tp1);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instruction_latch <= LATCH_RESET;
      instruction_latch_n <= ~LATCH_RESET;
    end
    else if (cpu_time.fetch && cpu_time.tp2)
    begin
      instruction_latch <= memory_data_lines;
      instruction_latch_n <= ~memory_data_lines;
    end
    else if (latch_clr)
    begin
      instruction_latch <= LATCH_RESET;
      instruction_latch_n <= ~LATCH_RESET;
    end
  end

  // ---------------------------------------------------------------
  // mode flip-flop
  // ---------------------------------------------------------------
  logic tp2_d;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tp2_d <= 1'b0;
    else
      tp2_d <= cpu_time.tp2 && cpu_time.fetch && arith_instr;
  end
  // trailing edge: the cycle after the pulse
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= ADT_MODE_A;
    else if (tp2_d && !cpu_time.tp2)
    begin
      if (swap_to_extended_set)
        mode <= ADT_MODE_B;
      else if (swap_to_legacy_set)
        mode <= ADT_MODE_A;
    end
  end

  // ---------------------------------------------------------------
  // decode roms
  // ---------------------------------------------------------------
  logic [ROM_DATA_W-1:0] rom1 [ROM_WORDS];
  logic [ROM_DATA_W-1:0] rom2 [ROM_WORDS];
  always_comb
  begin
    for (int i = 0; i < ROM_WORDS; i++)
    begin
      rom1[i] = ROM1_INIT[i*ROM_DATA_W +: ROM_DATA_W];
      rom2[i] = ROM2_INIT[i*ROM_DATA_W +: ROM_DATA_W];
    end
  end
  logic non_swap;
  logic rom1_en;
  logic rom2_en;
  assign non_swap = arith_instr && !swap_to_extended_set
    && !swap_to_legacy_set;
  assign rom1_en = non_swap && (cpu_time.fetch || cpu_time.execute);
  assign rom2_en = non_swap && cpu_time.fetch;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rom1_out_n <= 8'hFF;
      rom2_out_n <= 8'hFF;
      ma_increment <= 1'b0;
    end
    else
    begin
      // disabled roms drive all ones, i.e. no command
      rom1_out_n <= rom1_en ? rom1[rom_addr] : 8'hFF;
      rom2_out_n <= rom2_en ? rom2[rom_addr] : 8'hFF;
      // stored zero is an asserted command
      ma_increment <= rom2_en && !rom2[rom_addr][MA_INC_BIT];
    end
  end
  logic slow_add;
  assign slow_add = !rom1_out_n[ADD_SEL_BIT];

  // ---------------------------------------------------------------
  // timing generator
  // ---------------------------------------------------------------
  logic [2:0] div_cnt;
  logic ring_en;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 3'h0;
    else if (div_cnt == 3'(RING_DIV - 1))
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end
  assign ring_en = (div_cnt == 3'(RING_DIV - 1));

  logic sync_ff;
  logic [4:1] ring;
  logic next_ring1;
  logic next_ring2;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_ff <= 1'b0;
      unit_active_ff <= 1'b0;
    end
    else
    begin
      if (unit_start)
        sync_ff <= 1'b1;
      else if (stop_cond && unit_time_pulse)
        sync_ff <= 1'b0;
      if (ring_en)
        unit_active_ff <= sync_ff || (unit_active_ff && ring != 4'h0);
    end
  end
  // slow ring: 1->2->3->4, ~4->1 (8 clocks); fast ring skips 1 (6 clocks)
  assign next_ring1 = slow_add ? ~ring[4] : 1'b0;
  assign next_ring2 = slow_add ? ring[1] : ~ring[4];
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ring <= 4'h0;
    else if (ring_en && unit_active_ff)
      ring <= {ring[3], ring[2], next_ring2, next_ring1};
    else if (!unit_active_ff)
      ring <= 4'h0;
  end
  logic tp_raw;
  logic tp_raw_d;
  assign tp_raw = ring[2] && ring[3];
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tp_raw_d <= 1'b0;
    else
      tp_raw_d <= tp_raw;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_time_pulse <= 1'b0;
    else
      unit_time_pulse <= tp_raw && !tp_raw_d;
  end

  // ---------------------------------------------------------------
  // divide sequencing
  // ---------------------------------------------------------------
  logic corr_pending;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_counter <= 4'h0;
      div_active <= 1'b0;
      corr_pending <= 1'b0;
      link_bit <= 1'b0;
    end
    else if (div_start)
    begin
      step_counter <= 4'h0;
      // link set at start; unit only runs if the first step carried
      link_bit <= 1'b1;
      div_active <= div_first_carry;
      corr_pending <= 1'b0;
    end
    else if (div_active && unit_time_pulse)
    begin
      step_counter <= step_counter + 4'h1;
      if (step_counter == DIV_STEPS - 4'h2)
      begin
        div_active <= 1'b0;
        corr_pending <= 1'b1;
      end
    end
    else if (corr_pending)
    begin
      corr_pending <= 1'b0;
      link_bit <= 1'b0;
    end
    else if (unit_time_pulse)
      step_counter <= step_counter + 4'h1;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_ctl <= '0;
    else if (corr_pending)
    begin
      div_ctl.quotient_lsb <= q_bit11;
      div_ctl.true_form <= q_bit10;
      div_ctl.add_divisor <= !q_bit11;
      div_ctl.left_shift <= 1'b0;
      div_ctl.link_clear <= 1'b1;
    end
    else
    begin
      div_ctl.quotient_lsb <= q_bit10 ^ divide_sign_bit ^ carry_out;
      div_ctl.true_form <= (q_bit10 == q_bit11);
      div_ctl.add_divisor <= 1'b0;
      div_ctl.left_shift <= div_active;
      div_ctl.link_clear <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  quot_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !corr_pending |=> div_ctl.quotient_lsb ==
      ($past(q_bit10) ^ $past(divide_sign_bit) ^ $past(carry_out)))
    else $error("quotient bit wrong");
  corr_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    corr_pending |=> !div_ctl.left_shift && div_ctl.link_clear)
    else $error("correction step shifts");
  corr_true_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    corr_pending && q_bit10 |=> div_ctl.true_form)
    else $error("correction true form missing");
  corr_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    corr_pending |=> div_ctl.add_divisor == !$past(q_bit11))
    else $error("correction add wrong");
  latch_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cpu_time.fetch && cpu_time.tp2 |=>
      instruction_latch == $past(memory_data_lines)
      && instruction_latch_n == ~instruction_latch)
    else $error("latch load wrong");
  mode_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tp2_d |=> $stable(mode))
    else $error("mode changed off pulse");
  rom2_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cpu_time.fetch |=> rom2_out_n == 8'hFF && !ma_increment)
    else $error("second rom active outside fetch");
  pulse_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    unit_time_pulse |-> $past(ring[2] && ring[3]))
    else $error("time pulse without ring stages");
  ring_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !unit_active_ff |=> ring == 4'h0)
    else $error("ring runs while inactive");
  rom1_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !cpu_time.fetch && !cpu_time.execute |=> rom1_out_n == 8'hFF)
    else $error("first rom active outside fetch and execute");
  link_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    corr_pending && !div_start |=> !link_bit)
    else $error("link not cleared after divide");
  // start wins over stop, so only a clean stop must clear sync
  stop_sync_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stop_cond && unit_time_pulse && !unit_start |=> !sync_ff)
    else $error("stop did not clear sync");
  fast_ring_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ring_en && unit_active_ff && !slow_add |=> !ring[1])
    else $error("stage one not bypassed");
  slow_ring_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ring_en && unit_active_ff && slow_add
      |=> ring[1] == !$past(ring[4]))
    else $error("stage one not fed back");
endmodule : adt_unit

// file: common/adt_pkg.sv
// Purpose: constants and carriers for the arithmetic unit decode and timing
// Assumes: one 100 MHz core clock; processor time pulses arrive as inputs
// Notes: ring counter advances on a 20 MHz enable derived from core clock
//
// Summary of operation
// - quotient lsb is xor of bit10, sign, carry
// - divide runs thirteen steps, first checks overflow
// - correction step after last, no left shift
// - correction with bit10 set asserts true-form control
// - correction with bit11 clear adds divisor
// - latch captures memory data at fetch pulse two
// - latch clears at pulse four on interrupt without break, else fetch one
// - mode starts legacy, swap instructions switch it
// - mode clocked after pulse two on fetch decode
// - two 32x8 lookup roms, 5-bit address
// - first rom enabled fetch/execute, non-swap instruction
// - second rom enabled fetch only, non-swap instruction
// - rom outputs are active low
// - rom output 26 increments memory address
// - four-stage twisted ring plus sync and active
// - time pulse from ring stages two and three
// - add-select deasserted: six clocks, 300 ns pulses
// - add-select asserted: stage one included, 400 ns
// - ring advances on 20 MHz after active sets
// - stop condition clears sync, ends unit timing
package adt_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RING_MHZ = 20;
  localparam int RING_DIV = CLK_MHZ / RING_MHZ;
  localparam int SHIFT_PULSE_NS = 300;
  localparam int ADD_PULSE_NS = 400;
  localparam int RING_PERIOD_NS = 1000 / RING_MHZ;
  localparam int SHIFT_CLOCKS = SHIFT_PULSE_NS / RING_PERIOD_NS;
  localparam int ADD_CLOCKS = ADD_PULSE_NS / RING_PERIOD_NS;
  localparam logic [3:0] DIV_STEPS = 4'hD;
  localparam logic [11:0] LATCH_RESET = 12'h000;
  localparam int ROM_WORDS = 32;
  localparam int ROM_ADDR_W = 5;
  localparam int ROM_DATA_W = 8;
  localparam int ADD_SEL_BIT = 1;
  localparam int MA_INC_BIT = 5;
  typedef enum logic {ADT_MODE_A, ADT_MODE_B} adt_mode_e;
  typedef struct packed {
    logic fetch;
    logic execute;
    logic tp1;
    logic tp2;
    logic tp4;
    logic irq_pending;
    logic data_break;
  } adt_cpu_time_s;
  typedef struct packed {
    logic quotient_lsb;
    logic true_form;
    logic add_divisor;
    logic left_shift;
    logic link_clear;
  } adt_div_ctl_s;
endpackage : adt_pkg

// file: verif/adt_host_model.sv
// Purpose: processor side time states and time pulses for the unit
// Assumes: pulses last one core_clk cycle, driven 1 ns after the edge
// Notes: levels hold until the bench sets them again
module adt_host_model
  import adt_pkg::*;
(
  input wire logic core_clk,
  output adt_cpu_time_s cpu_time
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cpu_time = '0;

  // ---------------------------------------------------------------
  // major state and break levels
  // ---------------------------------------------------------------
  task automatic set_state(input logic f, input logic e, input logic irq,
                           input logic brk);
    @(posedge core_clk);
    #1;
    {cpu_time.fetch, cpu_time.execute} = {f, e};
    {cpu_time.irq_pending, cpu_time.data_break} = {irq, brk};
  endtask : set_state

  // ---------------------------------------------------------------
  // time pulses, sel bits are tp4 tp2 tp1; several at once allowed
  // ---------------------------------------------------------------
  task automatic pulse(input logic [2:0] sel);
    @(posedge core_clk);
    #1;
    {cpu_time.tp4, cpu_time.tp2, cpu_time.tp1} = sel;
    @(posedge core_clk);
    #1;
    {cpu_time.tp4, cpu_time.tp2, cpu_time.tp1} = 3'h0;
  endtask : pulse
endmodule : adt_host_model

// file: verif/arith_divide_decode_timing_tb_top.sv
// Purpose: self-checking bench for decode, latch, mode, divide, timing
// Assumes: rom word 3 of rom1 selects add, word 4 of rom2 bumps address
// Notes: every other rom word is blank, so it decodes to no command
module arith_divide_decode_timing_tb_top
  import adt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [255:0] R1 = ~(256'h1 << 25);
  localparam logic [255:0] R2 = ~(256'h1 << 37);
  // rows: fetch execute arith swap_ext swap_leg, addr, rom1, rom2, ma
  localparam logic [26:0] ROWS [9] = '{
    {5'b10100, 5'h03, 8'hFD, 8'hFF, 1'b0}, {5'b10100, 5'h04, 8'hFF, 8'hDF, 1'b1},
    {5'b01100, 5'h03, 8'hFD, 8'hFF, 1'b0}, {5'b01100, 5'h04, 8'hFF, 8'hFF, 1'b0},
    {5'b10110, 5'h03, 8'hFF, 8'hFF, 1'b0}, {5'b10101, 5'h04, 8'hFF, 8'hFF, 1'b0},
    {5'b10000, 5'h04, 8'hFF, 8'hFF, 1'b0}, {5'b00100, 5'h03, 8'hFF, 8'hFF, 1'b0},
    {5'b10100, 5'h00, 8'hFF, 8'hFF, 1'b0}};

  logic core_clk, reset_n, arith_instr, swap_to_extended_set;
  logic swap_to_legacy_set, div_start, div_first_carry, q_bit10, q_bit11;
  logic divide_sign_bit, carry_out, unit_start, stop_cond, ma_increment;
  logic div_active, link_bit, unit_time_pulse, unit_active_ff;
  logic [11:0] memory_data_lines, instruction_latch, instruction_latch_n;
  logic [4:0] rom_addr;
  logic [7:0] rom1_out_n, rom2_out_n;
  logic [3:0] step_counter;
  adt_cpu_time_s cpu_time;
  adt_mode_e mode;
  adt_div_ctl_s div_ctl;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  adt_host_model u_host (.core_clk(core_clk), .cpu_time(cpu_time));

  adt_unit #(.ROM1_INIT(R1), .ROM2_INIT(R2)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .cpu_time(cpu_time),
    .memory_data_lines(memory_data_lines), .arith_instr(arith_instr),
    .swap_to_extended_set(swap_to_extended_set),
    .swap_to_legacy_set(swap_to_legacy_set), .rom_addr(rom_addr),
    .div_start(div_start), .div_first_carry(div_first_carry),
    .q_bit10(q_bit10), .q_bit11(q_bit11), .divide_sign_bit(divide_sign_bit),
    .carry_out(carry_out), .unit_start(unit_start), .stop_cond(stop_cond),
    .instruction_latch(instruction_latch),
    .instruction_latch_n(instruction_latch_n), .mode(mode),
    .rom1_out_n(rom1_out_n), .rom2_out_n(rom2_out_n),
    .ma_increment(ma_increment), .div_ctl(div_ctl), .div_active(div_active),
    .link_bit(link_bit), .unit_time_pulse(unit_time_pulse),
    .unit_active_ff(unit_active_ff), .step_counter(step_counter));

  // ---------------------------------------------------------------
  // clock, timeout, checking and closing
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // a hung handshake would stall the run, so cap it well above need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  // ---------------------------------------------------------------
  // one divide; v holds bit10, bit11, sign, carry; carry picks add ring
  // ---------------------------------------------------------------
  task automatic run_div(input logic [3:0] v);
    int n;
    int c;
    int last;
    tick();
    {q_bit10, q_bit11, divide_sign_bit, carry_out} = v;
    rom_addr = v[0] ? 5'h03 : 5'h00;
    {div_first_carry, div_start} = 2'b11;
    tick();
    div_start = 1'b0;
    chk(link_bit, 1'b1, "link set");
    chk(div_active, 1'b1, "div active");
    chk(step_counter, 4'h0, "step clear");
    unit_start = 1'b1;
    tick();
    unit_start = 1'b0;
    {n, c, last} = '0;
    while (n < 12 && c < 700)
    begin
      tick();
      c++;
      if (unit_time_pulse === 1'b1)
      begin
        n++;
        if (n > 1)
          chk(16'(c - last), v[0] ? 16'd40 : 16'd30, "gap");
        last = c;
        if (n == 3)
        begin
          chk(unit_active_ff, 1'b1, "active");
          chk(div_ctl.quotient_lsb, v[3] ^ v[1] ^ v[0], "q lsb");
          chk(div_ctl.true_form, v[3] == v[2], "true form");
        end
      end
    end
    chk(16'(n), 16'd12, "pulses");
    c = 0;
    while (div_active !== 1'b0 && c < 20)
    begin
      tick();
      c++;
    end
    chk(div_active, 1'b0, "div done");
    chk(step_counter, 4'hC, "steps");
    tick();
    chk(link_bit, 1'b0, "link clear");
    chk(div_ctl.true_form, v[3], "fix form");
    chk(div_ctl.add_divisor, !v[2], "fix add");
    chk({div_ctl.left_shift, div_ctl.link_clear}, 2'b01, "fix ctl");
    stop_cond = 1'b1;
    c = 0;
    while (unit_active_ff !== 1'b0 && c < 100)
    begin
      tick();
      c++;
    end
    chk(unit_active_ff, 1'b0, "stopped");
    stop_cond = 1'b0;
  endtask : run_div

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [26:0] r;
    {reset_n, arith_instr, swap_to_extended_set, swap_to_legacy_set} = '0;
    {div_start, div_first_carry, q_bit10, q_bit11, divide_sign_bit} = '0;
    {carry_out, unit_start, stop_cond, rom_addr} = '0;
    memory_data_lines = 12'h000;
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (4) tick();
    chk({rom1_out_n, rom2_out_n}, 16'hFFFF, "rom reset");
    chk(instruction_latch_n, 12'hFFF, "latch reset");
    chk(mode, ADT_MODE_A, "mode reset");
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      u_host.set_state(r[26], r[25], 1'b0, 1'b0);
      {arith_instr, swap_to_extended_set, swap_to_legacy_set} = r[24:22];
      rom_addr = r[21:17];
      tick();
      chk(rom1_out_n, r[16:9], "rom1");
      chk(rom2_out_n, r[8:1], "rom2");
      chk(ma_increment, r[0], "ma inc");
    end
    // latch: load, clears, and load winning over a same-cycle clear
    {arith_instr, swap_to_extended_set, swap_to_legacy_set} = 3'b000;
    u_host.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      // second pattern is the first inverted, so every bit goes both ways
      memory_data_lines = k[0] ? 12'hA5C : 12'h5A3;
      u_host.pulse(3'b011);
      chk(instruction_latch, memory_data_lines, "load");
      chk(instruction_latch_n, k[0] ? 12'h5A3 : 12'hA5C, "load n");
    end
    u_host.pulse(3'b001);
    chk(instruction_latch, 12'h000, "fetch clear");
    u_host.pulse(3'b010);
    u_host.set_state(1'b1, 1'b0, 1'b1, 1'b1);
    u_host.pulse(3'b100);
    chk(instruction_latch, 12'hA5C, "break hold");
    u_host.set_state(1'b0, 1'b1, 1'b0, 1'b0);
    u_host.pulse(3'b001);
    chk(instruction_latch, 12'hA5C, "exec hold");
    u_host.set_state(1'b1, 1'b0, 1'b1, 1'b0);
    u_host.pulse(3'b100);
    chk(instruction_latch, 12'h000, "irq clear");
    // mode swaps, switched only after the pulse ends
    u_host.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    {arith_instr, swap_to_extended_set} = 2'b11;
    u_host.pulse(3'b010);
    chk(mode, ADT_MODE_A, "mode early");
    tick();
    chk(mode, ADT_MODE_B, "mode b");
    {arith_instr, swap_to_extended_set, swap_to_legacy_set} = 3'b001;
    u_host.pulse(3'b010);
    tick();
    chk(mode, ADT_MODE_B, "unqualified");
    arith_instr = 1'b1;
    u_host.pulse(3'b010);
    tick();
    chk(mode, ADT_MODE_A, "mode a");
    swap_to_legacy_set = 1'b0;
    u_host.set_state(1'b0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++)
      run_div(4'(i));
    // overflow: no carry keeps the unit off and the link set
    {div_first_carry, div_start} = 2'b01;
    tick();
    div_start = 1'b0;
    repeat (10) tick();
    chk({link_bit, div_active, unit_active_ff}, 3'b100, "overflow");
    // mid-run reset from mode b with a loaded latch and a set link
    u_host.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    {arith_instr, swap_to_extended_set} = 2'b11;
    u_host.pulse(3'b010);
    tick();
    chk(mode, ADT_MODE_B, "mode b again");
    reset_n = 1'b0;
    repeat (2) tick();
    reset_n = 1'b1;
    repeat (3) tick();
    chk(mode, ADT_MODE_A, "mode after reset");
    chk({link_bit, instruction_latch_n}, 13'h0FFF, "reset latch");
    report_and_stop();
  end
endmodule : arith_divide_decode_timing_tb_top
